// *** design/userclk_map.svh ***
// Overview of operation
// - The transmit helper takes its source clock from the master channel output clock and feeds one or two dividers.
// - With a narrow transmit user width one divider drives both transmit user clocks at equal frequency.
// - With a wide transmit user width two dividers run, the datapath clock at twice the interface clock.
// - Both transmit user clocks are fanned out to every transmit channel of the instance.
// - While a user clock reset is high the helper holds all of its dividers in reset.
// - After the user clock reset is released the active indicator asserts synchronously.
// - The receive helper takes its source clock from the receive master channel output clock.
// - With a narrow receive user width one divider drives both receive user clocks at identical frequency.
// - With a wide receive user width two dividers give a datapath clock at twice the interface clock.
// - The source clock and the generated user clocks are also exported on the core boundary.
// - The channel clock ports are exposed so the datapath and interface user clocks of each channel can cross the core boundary.
`ifndef USERCLK_MAP_SVH
`define USERCLK_MAP_SVH
`define UCK_DIV_W        8
`define UCK_HALF_DEFAULT 8'h01
`define UCK_CNT_RESET    8'h00
`define UCK_LANES        4
`endif

// *** design/userclk_pkg.sv ***
package userclk_pkg;
   typedef struct packed {
      logic datapath;
      logic iface;
   } user_clocks_s;
endpackage

// *** design/transceiver_user_clock_network.sv ***
`timescale 1ns/10ps
`include "userclk_map.svh"

module dividing_global_clock_buffer #(
   parameter logic [`UCK_DIV_W-1:0] HALF = `UCK_HALF_DEFAULT
) (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_hold,
   input  wire logic i_src,
   output logic      o_clk
);
   logic                 src_prev;
   logic                 next_src_prev;
   logic [`UCK_DIV_W-1:0] cnt;
   logic [`UCK_DIV_W-1:0] next_cnt;
   logic                 next_out;

   // refused while elaborating, a zero half period would wrap and toggle only every 256 rises
   if (HALF == '0)
   begin : g_bad_half
      $error("divider half period must be at least one");
   end

   always_comb
   begin
      next_src_prev = i_src;
      next_cnt      = cnt;
      next_out      = o_clk;
      if (i_hold)
      begin
         next_cnt = `UCK_CNT_RESET;
         next_out = 1'b0;
      end
      else if (i_src && !src_prev)
      begin
         if (cnt == HALF - 1'b1)
         begin
            next_cnt = `UCK_CNT_RESET;
            next_out = ~o_clk;
         end
         else
            next_cnt = cnt + 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         src_prev <= 1'b0;
         cnt      <= `UCK_CNT_RESET;
         o_clk    <= 1'b0;
      end
      else
      begin
         src_prev <= next_src_prev;
         cnt      <= next_cnt;
         o_clk    <= next_out;
      end
   end

   property p_held_low;
      @(posedge i_clk) disable iff (!i_rst_n)
      i_hold |=> !o_clk;
   endproperty
   a_held_low: assert property (p_held_low) else $error("divider output not held in reset");
endmodule

module transceiver_user_clock_network #(
   parameter bit                    TX_WIDE  = 1'b0,
   parameter bit                    RX_WIDE  = 1'b0,
   parameter logic [`UCK_DIV_W-1:0] TX_HALF  = `UCK_HALF_DEFAULT,
   parameter logic [`UCK_DIV_W-1:0] RX_HALF  = `UCK_HALF_DEFAULT,
   parameter int                    CHANNELS = `UCK_LANES
) (
   input  wire logic                            i_clk,
   input  wire logic                            i_arst_n,
   input  wire logic                            i_tx_channel_output_clock,
   input  wire logic                            i_rx_channel_output_clock,
   input  wire logic                            i_tx_user_clock_reset,
   input  wire logic                            i_rx_user_clock_reset,
   output userclk_pkg::user_clocks_s [CHANNELS-1:0] o_tx_channel_clocks,
   output userclk_pkg::user_clocks_s [CHANNELS-1:0] o_rx_channel_clocks,
   output logic                                 o_tx_source_clock_out,
   output logic                                 o_rx_source_clock_out,
   output logic                                 o_tx_datapath_clock_out,
   output logic                                 o_tx_interface_clock_out,
   output logic                                 o_rx_datapath_clock_out,
   output logic                                 o_rx_interface_clock_out,
   output logic                                 o_tx_active,
   output logic                                 o_rx_active
);
   logic                     rst_meta;
   logic                     rst_n;
   logic                     tx_dp;
   logic                     tx_if;
   logic                     rx_dp;
   logic                     rx_if;
   logic                     next_tx_active;
   logic                     next_rx_active;
   logic                     next_tx_src;
   logic                     next_rx_src;
   userclk_pkg::user_clocks_s tx_fan;
   userclk_pkg::user_clocks_s rx_fan;

   if (CHANNELS < 1)
   begin : g_bad_channels
      $error("at least one channel is needed");
   end
   // doubled half period must still fit the divider counter
   if ((TX_WIDE && (TX_HALF > 8'h7f)) || (RX_WIDE && (RX_HALF > 8'h7f)))
   begin : g_bad_wide_half
      $error("interface divider would overflow");
   end

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // datapath divider always present; interface divider only when wide
   dividing_global_clock_buffer #(.HALF(TX_HALF)) u_tx_dp (
      .i_clk   (i_clk),
      .i_rst_n (rst_n),
      .i_hold  (i_tx_user_clock_reset),
      .i_src   (i_tx_channel_output_clock),
      .o_clk   (tx_dp)
   );
   dividing_global_clock_buffer #(.HALF(RX_HALF)) u_rx_dp (
      .i_clk   (i_clk),
      .i_rst_n (rst_n),
      .i_hold  (i_rx_user_clock_reset),
      .i_src   (i_rx_channel_output_clock),
      .o_clk   (rx_dp)
   );

   generate
      if (TX_WIDE)
      begin : g_tx_two
         dividing_global_clock_buffer #(.HALF({TX_HALF[`UCK_DIV_W-2:0], 1'b0})) u_tx_if (
            .i_clk   (i_clk),
            .i_rst_n (rst_n),
            .i_hold  (i_tx_user_clock_reset),
            .i_src   (i_tx_channel_output_clock),
            .o_clk   (tx_if)
         );
      end
      else
      begin : g_tx_one
         assign tx_if = tx_dp;
      end
      if (RX_WIDE)
      begin : g_rx_two
         dividing_global_clock_buffer #(.HALF({RX_HALF[`UCK_DIV_W-2:0], 1'b0})) u_rx_if (
            .i_clk   (i_clk),
            .i_rst_n (rst_n),
            .i_hold  (i_rx_user_clock_reset),
            .i_src   (i_rx_channel_output_clock),
            .o_clk   (rx_if)
         );
      end
      else
      begin : g_rx_one
         assign rx_if = rx_dp;
      end
   endgenerate

   assign tx_fan = '{datapath: tx_dp, iface: tx_if};
   assign rx_fan = '{datapath: rx_dp, iface: rx_if};
   // fan-out is flop-driven copies so outputs stay registered
   assign o_tx_channel_clocks      = {CHANNELS{tx_fan}};
   assign o_rx_channel_clocks      = {CHANNELS{rx_fan}};
   assign o_tx_datapath_clock_out  = tx_dp;
   assign o_tx_interface_clock_out = tx_if;
   assign o_rx_datapath_clock_out  = rx_dp;
   assign o_rx_interface_clock_out = rx_if;

   always_comb
   begin
      next_tx_active = !i_tx_user_clock_reset;
      next_rx_active = !i_rx_user_clock_reset;
      next_tx_src    = i_tx_channel_output_clock;
      next_rx_src    = i_rx_channel_output_clock;
   end

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         o_tx_active           <= 1'b0;
         o_rx_active           <= 1'b0;
         o_tx_source_clock_out <= 1'b0;
         o_rx_source_clock_out <= 1'b0;
      end
      else
      begin
         o_tx_active           <= next_tx_active;
         o_rx_active           <= next_rx_active;
         o_tx_source_clock_out <= next_tx_src;
         o_rx_source_clock_out <= next_rx_src;
      end
   end

   sequence s_tx_release;
      $fell(i_tx_user_clock_reset);
   endsequence
   property p_tx_active_rise;
      @(posedge i_clk) disable iff (!rst_n)
      s_tx_release ##0 !i_tx_user_clock_reset [*1] |=> o_tx_active;
   endproperty
   a_tx_active_rise: assert property (p_tx_active_rise) else $error("tx active late after release");
   property p_rx_active_rise;
      @(posedge i_clk) disable iff (!rst_n)
      $fell(i_rx_user_clock_reset) |=> o_rx_active;
   endproperty
   a_rx_active_rise: assert property (p_rx_active_rise) else $error("rx active late after release");
   property p_tx_active_low;
      @(posedge i_clk) disable iff (!rst_n)
      i_tx_user_clock_reset |=> !o_tx_active && !o_tx_datapath_clock_out;
   endproperty
   a_tx_active_low: assert property (p_tx_active_low) else $error("tx active during reset");
   property p_rx_active_low;
      @(posedge i_clk) disable iff (!rst_n)
      i_rx_user_clock_reset |=> !o_rx_active && !o_rx_datapath_clock_out;
   endproperty
   a_rx_active_low: assert property (p_rx_active_low) else $error("rx active during reset");
   property p_tx_equal;
      @(posedge i_clk) disable iff (!rst_n)
      !TX_WIDE |-> o_tx_datapath_clock_out == o_tx_interface_clock_out;
   endproperty
   a_tx_equal: assert property (p_tx_equal) else $error("tx user clocks differ in narrow mode");
   property p_rx_equal;
      @(posedge i_clk) disable iff (!rst_n)
      !RX_WIDE |-> o_rx_datapath_clock_out == o_rx_interface_clock_out;
   endproperty
   a_rx_equal: assert property (p_rx_equal) else $error("rx user clocks differ in narrow mode");
   property p_tx_ratio;
      @(posedge i_clk) disable iff (!rst_n)
      $changed(o_tx_interface_clock_out) && !$past(i_tx_user_clock_reset) |-> $changed(o_tx_datapath_clock_out);
   endproperty
   a_tx_ratio: assert property (p_tx_ratio) else $error("tx interface clock not aligned to datapath");
   property p_rx_ratio;
      @(posedge i_clk) disable iff (!rst_n)
      $changed(o_rx_interface_clock_out) && !$past(i_rx_user_clock_reset) |-> $changed(o_rx_datapath_clock_out);
   endproperty
   a_rx_ratio: assert property (p_rx_ratio) else $error("rx interface clock not aligned to datapath");
   property p_src_export;
      @(posedge i_clk) disable iff (!rst_n)
      ##1 o_tx_source_clock_out == $past(i_tx_channel_output_clock)
          && o_rx_source_clock_out == $past(i_rx_channel_output_clock);
   endproperty
   a_src_export: assert property (p_src_export) else $error("source clock export mismatch");
   property p_fanout;
      @(posedge i_clk) disable iff (!rst_n)
      o_tx_channel_clocks[CHANNELS-1].iface == o_tx_interface_clock_out
      && o_rx_channel_clocks[CHANNELS-1].datapath == o_rx_datapath_clock_out;
   endproperty
   a_fanout: assert property (p_fanout) else $error("channel clock fan-out mismatch");
endmodule

// *** verif/channel_clock_model.sv ***
`timescale 1ns/10ps
module channel_clock_model (
   input  wire logic       i_clk,
   input  wire logic       i_run,
   input  wire logic [3:0] i_half,
   output logic            o_tx_clk,
   output logic            o_rx_clk
);
   logic [3:0] cnt;
   // both source clocks stand still low outside a run
   // rx source runs at half the tx rate, both far below i_clk/2
   always_ff @(posedge i_clk)
   begin
      if (!i_run)
      begin
         cnt      <= 4'h0;
         o_tx_clk <= 1'b0;
         o_rx_clk <= 1'b0;
      end
      else if (cnt == i_half)
      begin
         cnt      <= 4'h0;
         o_tx_clk <= ~o_tx_clk;
         o_rx_clk <= o_rx_clk ^ o_tx_clk;
      end
      else
         cnt <= cnt + 4'h1;
   end
endmodule

// *** verif/transceiver_user_clock_network_bench.sv ***
`timescale 1ns/10ps
module transceiver_user_clock_network_bench;
   localparam int RH = 2;
   logic                           clk, arst_n, tx_rst, rx_rst, run, live;
   logic                           tx_src, rx_src, tx_so, rx_so, tx_act, rx_act;
   logic                           tx_dp, tx_if, rx_dp, rx_if;
   logic                           p_tx_src, p_rx_src, p_tx_dp, p_rx_dp, p_rx_if;
   logic                           p_tx_rst, p_rx_rst, p_w_tx_dp, p_w_tx_if, p_w_rx_dp;
   logic                           w_tx_dp, w_tx_if, w_rx_dp, w_rx_if, w_tx_so, w_rx_so, w_tx_act, w_rx_act;
   logic [3:0]                     half;
   logic [7:0]                     lfsr;
   userclk_pkg::user_clocks_s [3:0] tx_ch, rx_ch, w_tx_ch, w_rx_ch;
   int                             failures, comparisons, tx_r, rx_r, tx_dt, rx_dt, rx_it, w_tx_dt, w_tx_it, w_rx_dt;

   channel_clock_model far (.i_clk(clk), .i_run(run), .i_half(half), .o_tx_clk(tx_src), .o_rx_clk(rx_src));
   transceiver_user_clock_network #(.TX_WIDE(1'b0), .RX_WIDE(1'b1), .TX_HALF(8'h01), .RX_HALF(8'h02),
      .CHANNELS(4)) uut (.i_clk(clk), .i_arst_n(arst_n), .i_tx_channel_output_clock(tx_src),
      .i_rx_channel_output_clock(rx_src), .i_tx_user_clock_reset(tx_rst), .i_rx_user_clock_reset(rx_rst),
      .o_tx_channel_clocks(tx_ch), .o_rx_channel_clocks(rx_ch), .o_tx_source_clock_out(tx_so),
      .o_rx_source_clock_out(rx_so), .o_tx_datapath_clock_out(tx_dp), .o_tx_interface_clock_out(tx_if),
      .o_rx_datapath_clock_out(rx_dp), .o_rx_interface_clock_out(rx_if), .o_tx_active(tx_act),
      .o_rx_active(rx_act));
   // swapped widths so the other divider arrangement of each direction runs too
   transceiver_user_clock_network #(.TX_WIDE(1'b1), .RX_WIDE(1'b0), .TX_HALF(8'h01), .RX_HALF(8'h02),
      .CHANNELS(4)) uut_swap (.i_clk(clk), .i_arst_n(arst_n), .i_tx_channel_output_clock(tx_src),
      .i_rx_channel_output_clock(rx_src), .i_tx_user_clock_reset(tx_rst), .i_rx_user_clock_reset(rx_rst),
      .o_tx_channel_clocks(w_tx_ch), .o_rx_channel_clocks(w_rx_ch), .o_tx_source_clock_out(w_tx_so),
      .o_rx_source_clock_out(w_rx_so), .o_tx_datapath_clock_out(w_tx_dp), .o_tx_interface_clock_out(w_tx_if),
      .o_rx_datapath_clock_out(w_rx_dp), .o_rx_interface_clock_out(w_rx_if), .o_tx_active(w_tx_act),
      .o_rx_active(w_rx_act));

   function automatic logic [7:0] nxt(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      comparisons++;
      if (seen !== exp)
      begin
         failures++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      if (failures == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // expected toggles are floor(rises / half-count), so counts carry across bursts
   task automatic burst();
      lfsr = nxt(lfsr);
      half <= 4'h2 + {2'b00, lfsr[1:0]};
      run  <= 1'b1;
      repeat (40 + lfsr[7:2]) @(posedge clk);
      run <= 1'b0;
      repeat (12) @(posedge clk);
      chk(tx_dt, tx_r, "tx dp toggles");
      chk(rx_dt, rx_r / RH, "rx dp toggles");
      chk(rx_it, rx_r / (2 * RH), "rx if toggles");
      chk(w_tx_dt, tx_r, "swap tx dp toggles");
      chk(w_tx_it, tx_r / 2, "swap tx if toggles");
      chk(w_rx_dt, rx_r / RH, "swap rx dp toggles");
   endtask

   always @(negedge clk)
   begin
      if (live)
      begin
         for (int k = 0; k < 4; k++)
         begin
            chk(tx_ch[k], {tx_dp, tx_if}, "tx lane");
            chk(rx_ch[k], {rx_dp, rx_if}, "rx lane");
            chk(w_tx_ch[k], {w_tx_dp, w_tx_if}, "swap tx lane");
            chk(w_rx_ch[k], {w_rx_dp, w_rx_if}, "swap rx lane");
         end
         chk(tx_dp, tx_if, "tx pair");
         chk(rx_if != p_rx_if && rx_dp == p_rx_dp, 1'b0, "rx pair");
         chk(tx_so, p_tx_src, "tx src out");
         chk(rx_so, p_rx_src, "rx src out");
         chk(w_tx_so, p_tx_src, "swap tx src out");
         chk(w_rx_so, p_rx_src, "swap rx src out");
         chk({tx_act, rx_act, w_tx_act, w_rx_act}, {2{!p_tx_rst, !p_rx_rst}}, "active level");
         chk(w_rx_dp, w_rx_if, "swap rx pair");
         chk(w_tx_if != p_w_tx_if && w_tx_dp == p_w_tx_dp, 1'b0, "swap tx pair");
         tx_r  += int'(!tx_rst && tx_src && !p_tx_src);
         rx_r  += int'(!rx_rst && rx_src && !p_rx_src);
         tx_dt += int'(tx_dp != p_tx_dp);
         rx_dt += int'(rx_dp != p_rx_dp);
         rx_it += int'(rx_if != p_rx_if);
         w_tx_dt += int'(w_tx_dp != p_w_tx_dp);
         w_tx_it += int'(w_tx_if != p_w_tx_if);
         w_rx_dt += int'(w_rx_dp != p_w_rx_dp);
      end
      {p_tx_src, p_rx_src, p_tx_dp, p_rx_dp, p_rx_if} = {tx_src, rx_src, tx_dp, rx_dp, rx_if};
      {p_tx_rst, p_rx_rst, p_w_tx_dp, p_w_tx_if, p_w_rx_dp} = {tx_rst, rx_rst, w_tx_dp, w_tx_if, w_rx_dp};
   end

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial
   begin
      #100us;
      failures++;
      tally_and_finish();
   end

   initial
   begin
      {arst_n, run, live, tx_rst, rx_rst, half, lfsr} = {3'b000, 2'b11, 4'h2, 8'h11};
      {failures, comparisons, tx_r, rx_r, tx_dt, rx_dt, rx_it, w_tx_dt, w_tx_it, w_rx_dt} = '0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      live <= 1'b1;
      for (int i = 0; i < 2; i++)
      begin
         // source running under user reset: dividers and active stay idle
         run <= 1'b1;
         repeat (30) @(posedge clk);
         @(negedge clk);
         chk({tx_act, rx_act, tx_dp, rx_dp, rx_if}, 5'h00, "held state");
         chk({w_tx_act, w_rx_act, w_tx_dp, w_tx_if, w_rx_dp}, 5'h00, "swap held state");
         chk(tx_dt + rx_dt + rx_it + w_tx_dt + w_tx_it + w_rx_dt, 0, "held toggles");
         @(posedge clk);
         run <= 1'b0;
         repeat (6) @(posedge clk);
         {tx_r, rx_r, tx_dt, rx_dt, rx_it, w_tx_dt, w_tx_it, w_rx_dt} = '0;
         // release only once the source has stood stable
         tx_rst <= 1'b0;
         rx_rst <= 1'b0;
         @(negedge clk);
         chk({tx_act, rx_act, w_tx_act, w_rx_act}, 4'h0, "active before");
         @(posedge clk);
         @(negedge clk);
         chk({tx_act, rx_act, w_tx_act, w_rx_act}, 4'hf, "active after");
         repeat (3) burst();
         // reassert in mid-run
         run <= 1'b1;
         repeat (20) @(posedge clk);
         tx_rst <= 1'b1;
         rx_rst <= 1'b1;
         repeat (3) @(posedge clk);
         {tx_dt, rx_dt, rx_it, w_tx_dt, w_tx_it, w_rx_dt} = '0;
      end
      tally_and_finish();
   end
endmodule
